// ===== src/fsr_pkg.sv
// Constants, types and command encodings for the flash status host controller
// Functional notes
// - Toggle check reads the status byte twice
// - Timeout bit set: repeat the toggle comparison once
// - Bits 6..1 meaningless until ready flag reads 1
// - Poll until ready before issuing any suspend
// - Prefer extended status over data polling
// - Two unlock writes then 90h enter identification
package fsr_pkg;
	localparam int ADDR_W = 26;
	localparam int DATA_W = 16;

	// ==========================================================
	// Status bit positions
	localparam int BIT_READY   = 7;
	localparam int BIT_TOGGLE  = 6;
	localparam int BIT_TIMEOUT = 5;
	localparam logic [DATA_W-1:0] ESR_VALID_MASK = 16'h00FE;
	localparam logic [DATA_W-1:0] ESR_BUSY_MASK  = 16'h0080;

	// ==========================================================
	// Command words and addresses
	localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 26'h0000555;
	localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 26'h00002AA;
	localparam logic [7:0] UNLOCK_DATA1 = 8'hAA;
	localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
	localparam logic [7:0] CMD_ID_ENTER = 8'h90;
	localparam logic [7:0] CMD_RESET    = 8'hF0;
	localparam logic [7:0] CMD_ESR_RD   = 8'h75;
	localparam logic [7:0] CMD_ESR_CLR  = 8'h71;
	localparam logic [7:0] CMD_E_SUSP   = 8'hB0;
	localparam logic [7:0] CMD_E_RES    = 8'h30;
	localparam logic [7:0] CMD_P_SUSP   = 8'h51;
	localparam logic [7:0] CMD_P_RES    = 8'h50;

	// ==========================================================
	// Bus timing
	localparam int CLK_NS   = 20;
	localparam int T_WP_NS  = 35;
	localparam int T_WPH_NS = 20;
	localparam int T_ACC_NS = 70;
	localparam int WP_CYC   = (T_WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int WPH_CYC  = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
	localparam int ACC_CYC  = (T_ACC_NS + CLK_NS - 1) / CLK_NS;

	// ==========================================================
	// Types
	typedef enum logic [3:0] {
		OP_READ, OP_TOGGLE_WAIT, OP_ESR_READ, OP_ESR_CLEAR, OP_ERASE_SUSPEND,
		OP_ERASE_RESUME, OP_PROG_SUSPEND, OP_PROG_RESUME, OP_ID_ENTER, OP_ID_EXIT
	} fsr_op_t;

	typedef struct packed {
		fsr_op_t             op;
		logic [ADDR_W-1:0]   addr;
	} fsr_req_t;

	typedef struct packed {
		logic [DATA_W-1:0]   data;
		logic                ready;
		logic                fail;
	} fsr_rsp_t;

	typedef struct packed {
		logic                ce_n;
		logic                we_n;
		logic                oe_n;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   dq;
		logic                dq_oe;
	} fsr_pins_t;

	localparam fsr_pins_t PINS_IDLE = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
		addr: '0, dq: '0, dq_oe: 1'b0};
endpackage : fsr_pkg

// ===== src/fsr_host.sv
// Host-side controller that issues status commands and polls the flash
`timescale 1ns/1ps
`default_nettype none
module fsr_host #(
	parameter int WP_CYC  = fsr_pkg::WP_CYC,
	parameter int WPH_CYC = fsr_pkg::WPH_CYC,
	parameter int ACC_CYC = fsr_pkg::ACC_CYC
) (
	input  wire logic                          CLK,
	input  wire logic                          RST,
	input  wire logic                          CMD_VALID,
	output logic                               CMD_READY,
	input  wire fsr_pkg::fsr_req_t             CMD,
	output logic                               RSP_VALID,
	output fsr_pkg::fsr_rsp_t                  RSP,
	output fsr_pkg::fsr_pins_t                 FLASH,
	input  wire logic [fsr_pkg::DATA_W-1:0]    FLASH_DQ_IN,
	input  wire logic                          FLASH_READY_BUSY_OUT
);
	if (WP_CYC < 1 || WP_CYC > 15 || WPH_CYC < 1 || WPH_CYC > 15 ||
		ACC_CYC < 1 || ACC_CYC > 15) begin : g_bad_timing
		$error("fsr_host: timing counts must be 1..15");
	end

	typedef enum logic [2:0] {S_IDLE, S_WRITE, S_WGAP, S_READ, S_EVAL, S_DONE} fsr_state_t;

	// ==========================================================
	// Sequencer state
	fsr_state_t                  state_reg, state_next;
	fsr_pkg::fsr_req_t           req_reg, req_next;
	logic [3:0]                  cnt_reg, cnt_next;
	logic [1:0]                  step_reg, step_next;
	logic                        phase_reg, phase_next;
	logic                        first_reg, first_next;
	logic                        retry_reg, retry_next;
	logic [fsr_pkg::DATA_W-1:0]  rd_reg, rd_next, rd1_reg, rd1_next;
	fsr_pkg::fsr_rsp_t           rsp_reg, rsp_next;
	fsr_pkg::fsr_pins_t          pins_reg, pins_next;
	logic [1:0]                  n_wr;
	logic                        need_rd;
	logic [fsr_pkg::ADDR_W-1:0]  wr_addr;
	logic [7:0]                  wr_data;

	assign CMD_READY = (state_reg == S_IDLE);
	assign RSP_VALID = (state_reg == S_DONE);
	assign RSP       = rsp_reg;
	assign FLASH     = pins_reg;

	// Shape of the operation; suspend phase 0 is the ready poll
	always_comb begin
		n_wr    = 2'd1;
		need_rd = 1'b0;
		unique case (req_reg.op)
			fsr_pkg::OP_READ, fsr_pkg::OP_TOGGLE_WAIT: begin
				n_wr    = 2'd0;
				need_rd = 1'b1;
			end
			fsr_pkg::OP_ESR_READ: need_rd = 1'b1;
			fsr_pkg::OP_ERASE_SUSPEND, fsr_pkg::OP_PROG_SUSPEND: need_rd = !phase_reg;
			fsr_pkg::OP_ID_ENTER: n_wr = 2'd3;
			default: ;
		endcase
	end

	// Word of the write about to start, from next values: the flash takes
	// the address at the falling strobe, so it must stand from the first cycle
	always_comb begin
		wr_addr = fsr_pkg::UNLOCK_ADDR1;
		wr_data = fsr_pkg::CMD_RESET;
		unique case (req_next.op)
			fsr_pkg::OP_ESR_READ:  wr_data = fsr_pkg::CMD_ESR_RD;
			fsr_pkg::OP_ESR_CLEAR: wr_data = fsr_pkg::CMD_ESR_CLR;
			fsr_pkg::OP_ERASE_RESUME: begin
				wr_addr = req_next.addr;
				wr_data = fsr_pkg::CMD_E_RES;
			end
			fsr_pkg::OP_PROG_RESUME: begin
				wr_addr = req_next.addr;
				wr_data = fsr_pkg::CMD_P_RES;
			end
			fsr_pkg::OP_ERASE_SUSPEND, fsr_pkg::OP_PROG_SUSPEND: begin
				if (phase_next) begin
					wr_addr = req_next.addr;
					wr_data = (req_next.op == fsr_pkg::OP_ERASE_SUSPEND) ?
						fsr_pkg::CMD_E_SUSP : fsr_pkg::CMD_P_SUSP;
				end else begin
					wr_data = fsr_pkg::CMD_ESR_RD;
				end
			end
			fsr_pkg::OP_ID_ENTER: begin
				unique case (step_next)
					2'd0: wr_data = fsr_pkg::UNLOCK_DATA1;
					2'd1: begin
						wr_addr = fsr_pkg::UNLOCK_ADDR2;
						wr_data = fsr_pkg::UNLOCK_DATA2;
					end
					default: wr_data = fsr_pkg::CMD_ID_ENTER;
				endcase
			end
			fsr_pkg::OP_ID_EXIT: wr_data = fsr_pkg::CMD_RESET;
			default: ;
		endcase
	end

	// ==========================================================
	// Next-state logic
	always_comb begin
		state_next = state_reg;
		req_next   = req_reg;
		cnt_next   = cnt_reg;
		step_next  = step_reg;
		phase_next = phase_reg;
		first_next = first_reg;
		retry_next = retry_reg;
		rd_next    = rd_reg;
		rd1_next   = rd1_reg;
		rsp_next   = rsp_reg;
		unique case (state_reg)
			S_IDLE: if (CMD_VALID) begin
				req_next   = CMD;
				step_next  = 2'd0;
				phase_next = 1'b0;
				first_next = 1'b1;
				retry_next = 1'b0;
				cnt_next   = 4'h0;
				state_next = (CMD.op == fsr_pkg::OP_READ ||
					CMD.op == fsr_pkg::OP_TOGGLE_WAIT) ? S_READ : S_WRITE;
			end
			S_WRITE: if (cnt_reg == 4'(WP_CYC - 1)) begin
				cnt_next   = 4'h0;
				state_next = S_WGAP;
			end else begin
				cnt_next = cnt_reg + 4'h1;
			end
			S_WGAP: if (cnt_reg == 4'(WPH_CYC - 1)) begin
				cnt_next = 4'h0;
				if (step_reg + 2'd1 < n_wr) begin
					step_next  = step_reg + 2'd1;
					state_next = S_WRITE;
				end else begin
					state_next = need_rd ? S_READ : S_DONE;
				end
			end else begin
				cnt_next = cnt_reg + 4'h1;
			end
			S_READ: if (cnt_reg == 4'(ACC_CYC - 1)) begin
				cnt_next   = 4'h0;
				rd_next    = FLASH_DQ_IN;
				state_next = S_EVAL;
			end else begin
				cnt_next = cnt_reg + 4'h1;
			end
			S_EVAL: begin
				state_next = S_DONE;
				rsp_next   = '{data: rd_reg, ready: rd_reg[fsr_pkg::BIT_READY], fail: 1'b0};
				unique case (req_reg.op)
					fsr_pkg::OP_TOGGLE_WAIT: begin
						if (first_reg) begin
							rd1_next   = rd_reg;
							first_next = 1'b0;
							state_next = S_READ;
						end else if (rd1_reg[fsr_pkg::BIT_TOGGLE] ==
							rd_reg[fsr_pkg::BIT_TOGGLE]) begin
							rsp_next.fail = 1'b0;
						end else if (rd_reg[fsr_pkg::BIT_TIMEOUT] && retry_reg) begin
							rsp_next.fail = 1'b1;
						end else begin
							retry_next = retry_reg | rd_reg[fsr_pkg::BIT_TIMEOUT];
							first_next = 1'b1;
							state_next = S_READ;
						end
					end
					fsr_pkg::OP_ESR_READ: begin
						// Bits 6..1 are stale while busy, so they are hidden
						rsp_next.data = rd_reg & (rd_reg[fsr_pkg::BIT_READY] ?
							fsr_pkg::ESR_VALID_MASK : fsr_pkg::ESR_BUSY_MASK);
					end
					fsr_pkg::OP_ERASE_SUSPEND, fsr_pkg::OP_PROG_SUSPEND: begin
						step_next  = 2'd0;
						state_next = S_WRITE;
						if (rd_reg[fsr_pkg::BIT_READY])
							phase_next = 1'b1;
					end
					default: ;
				endcase
			end
			S_DONE: state_next = S_IDLE;
			default: state_next = S_IDLE;
		endcase
	end

	// Pin image follows the next state so pins line up with state_reg
	always_comb begin
		pins_next = fsr_pkg::PINS_IDLE;
		unique case (state_next)
			S_WRITE, S_WGAP: begin
				pins_next.ce_n  = 1'b0;
				pins_next.we_n  = (state_next == S_WGAP);
				pins_next.dq_oe = 1'b1;
				pins_next.addr  = wr_addr;
				pins_next.dq    = {8'h00, wr_data};
			end
			S_READ: begin
				pins_next.ce_n = 1'b0;
				pins_next.oe_n = 1'b0;
				pins_next.addr = req_next.addr;
			end
			default: ;
		endcase
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			state_reg <= S_IDLE;
			req_reg   <= '{op: fsr_pkg::OP_READ, addr: '0};
			cnt_reg   <= 4'h0;
			step_reg  <= 2'd0;
			phase_reg <= 1'b0;
			first_reg <= 1'b1;
			retry_reg <= 1'b0;
			rd_reg    <= '0;
			rd1_reg   <= '0;
			rsp_reg   <= '0;
			pins_reg  <= fsr_pkg::PINS_IDLE;
		end else begin
			state_reg <= state_next;
			req_reg   <= req_next;
			cnt_reg   <= cnt_next;
			step_reg  <= step_next;
			phase_reg <= phase_next;
			first_reg <= first_next;
			retry_reg <= retry_next;
			rd_reg    <= rd_next;
			rd1_reg   <= rd1_next;
			rsp_reg   <= rsp_next;
			pins_reg  <= pins_next;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	sequence eval_second_s;
		state_reg == S_EVAL && req_reg.op == fsr_pkg::OP_TOGGLE_WAIT && !first_reg;
	endsequence

	pair_first_read_a: assert property (
		state_reg == S_EVAL && req_reg.op == fsr_pkg::OP_TOGGLE_WAIT && first_reg
		|=> state_reg == S_READ && !first_reg && rd1_reg == $past(rd_reg))
		else $error("toggle pair did not take a second read");
	toggle_done_equal_a: assert property (
		RSP_VALID && req_reg.op == fsr_pkg::OP_TOGGLE_WAIT && !RSP.fail
		|-> rd1_reg[fsr_pkg::BIT_TOGGLE] == rd_reg[fsr_pkg::BIT_TOGGLE])
		else $error("toggle wait ended while bit still toggling");
	timeout_recheck_a: assert property (
		eval_second_s ##0 (rd1_reg[fsr_pkg::BIT_TOGGLE] != rd_reg[fsr_pkg::BIT_TOGGLE] &&
		rd_reg[fsr_pkg::BIT_TIMEOUT] && !retry_reg)
		|=> state_reg == S_READ && retry_reg && first_reg)
		else $error("timeout did not trigger one more toggle pair");
	timeout_fail_a: assert property (
		RSP_VALID && req_reg.op == fsr_pkg::OP_TOGGLE_WAIT && RSP.fail |-> retry_reg)
		else $error("toggle failure reported without recheck");
	busy_bits_hidden_a: assert property (
		RSP_VALID && req_reg.op == fsr_pkg::OP_ESR_READ && !RSP.ready
		|-> RSP.data == (fsr_pkg::ESR_BUSY_MASK & rd_reg))
		else $error("busy status leaked bits 6..1");
	suspend_after_ready_a: assert property (
		$rose(phase_reg) |-> $past(rd_reg[fsr_pkg::BIT_READY]) && state_reg == S_WRITE)
		else $error("suspend issued before ready flag read as 1");
	id_entry_cmd_a: assert property (
		state_reg == S_WRITE && req_reg.op == fsr_pkg::OP_ID_ENTER && step_reg == 2'd2
		|-> FLASH.dq[7:0] == fsr_pkg::CMD_ID_ENTER && $past(step_reg, WP_CYC + WPH_CYC) == 2'd1)
		else $error("identification entry not preceded by unlock writes");
	we_pulse_width_a: assert property (
		$fell(FLASH.we_n) |-> !FLASH.we_n ##1 !FLASH.we_n ##1 FLASH.we_n)
		else $error("write strobe width wrong");
endmodule : fsr_host
`default_nettype wire

// ===== testbench/fsr_flash_model.sv
// Behavioural flash device answering status commands on the parallel bus
`timescale 1ns/1ps
`default_nettype none
module fsr_flash_model #(
	parameter logic [15:0] ARRAY_WORD = 16'h1234,
	parameter logic [9:0]  ERASE_SECTOR = 10'h001,
	parameter logic [15:0] ID_WORD    = 16'h005A // Arbitrary value
) (
	input  wire fsr_pkg::fsr_pins_t PINS,
	input  wire logic               BUSY_REQ,
	input  wire logic               TIMEOUT,
	input  wire logic               ERASE_OP,
	input  wire logic               RES_LOAD,
	input  wire logic [15:0]        RES_IN,
	output logic [15:0]             DQ,
	output logic                    READY_BUSY_OUT
);
	logic [15:0] res_reg, snap_reg, val;
	logic        esusp, psusp, snap_pend, id_mode, tog, busy, wb_abort, in_erase;
	int          unl;
	initial begin
		res_reg = 16'h0000;
		{esusp, psusp, snap_pend, id_mode, tog, wb_abort} = 6'h00;
		unl = 0;
	end
	// An aborted buffered write drops back to read mode at once
	assign busy = BUSY_REQ && !esusp && !psusp && !wb_abort;
	assign in_erase = ERASE_OP && (PINS.addr[25:16] == ERASE_SECTOR);
	assign READY_BUSY_OUT = !busy;
	// ==========================================================
	// Command decode on the write strobe
	always @(posedge PINS.we_n) begin
		if (PINS.dq[7:0] == fsr_pkg::CMD_ESR_RD) begin
			snap_reg = {8'h00, !busy, esusp, res_reg[5:3], psusp, res_reg[1], 1'b0};
			snap_pend = 1'b1;
		end else if (!busy) begin
			case (PINS.dq[7:0])
				fsr_pkg::CMD_ESR_CLR, fsr_pkg::CMD_RESET: begin
					res_reg = 16'h0000;
					id_mode = 1'b0;
				end
				fsr_pkg::CMD_E_SUSP: esusp = 1'b1;
				fsr_pkg::CMD_E_RES:  esusp = 1'b0;
				fsr_pkg::CMD_P_SUSP: psusp = 1'b1;
				fsr_pkg::CMD_P_RES:  psusp = 1'b0;
				fsr_pkg::CMD_ID_ENTER: if (unl == 2) id_mode = 1'b1;
				default: ;
			endcase
		end
		unl = (PINS.dq[7:0] == 8'hAA) ? 1 : (PINS.dq[7:0] == 8'h55 && unl == 1) ? 2 : 0;
	end
	// Toggle advances once per completed busy read; a read returning a status snapshot leaves it
	always @(posedge PINS.oe_n) begin
		if (snap_pend) snap_pend = 1'b0;
		else if (busy) tog = !tog;
	end
	// Bit 8 of the load marks a program aimed at the erase-suspended sector
	always @(posedge RES_LOAD) begin
		res_reg = res_reg | (RES_IN & 16'h003A);
		if (RES_IN[8] && esusp) res_reg[4] = 1'b1;
		if (RES_IN[3] && BUSY_REQ) wb_abort = 1'b1;
	end
	always @(negedge BUSY_REQ) wb_abort = 1'b0;
	always_comb begin
		if (snap_pend) val = snap_reg;
		else if (busy) val = {8'h00, !ARRAY_WORD[7] && !ERASE_OP, tog, TIMEOUT, 1'b0, ERASE_OP,
			in_erase && tog, 2'b00};
		else if (id_mode) val = ID_WORD;
		else val = ARRAY_WORD;
	end
	// Released bus shows the inverse so a stale value never passes
	assign DQ = (!PINS.ce_n && !PINS.oe_n) ? val : ~val;
endmodule : fsr_flash_model
`default_nettype wire

// ===== testbench/test_fsr_host.sv
// Self-checking bench for the flash status host controller
`timescale 1ns/1ps
`default_nettype none
module test_fsr_host;
	logic               clk, rst, cmd_valid, cmd_ready, rsp_valid, busy_req, timeout, res_load;
	logic [15:0]        res_in, dq_in;
	logic               ready_busy_out;
	logic               erase_op;
	fsr_pkg::fsr_req_t  cmd;
	fsr_pkg::fsr_rsp_t  rsp, got;
	fsr_pkg::fsr_pins_t pins;
	int                 miscompares, n_tests;
	fsr_host fsr_host_i (.CLK(clk), .RST(rst), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
		.CMD(cmd), .RSP_VALID(rsp_valid), .RSP(rsp), .FLASH(pins), .FLASH_DQ_IN(dq_in),
		.FLASH_READY_BUSY_OUT(ready_busy_out));
	fsr_flash_model fsr_flash_model_i (.PINS(pins), .BUSY_REQ(busy_req), .TIMEOUT(timeout),
		.ERASE_OP(erase_op),
		.RES_LOAD(res_load), .RES_IN(res_in), .DQ(dq_in), .READY_BUSY_OUT(ready_busy_out));
	always #10 clk = !clk;
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : print_verdict
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] act);
		n_tests++;
		if (act !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, act);
		end
	endtask : chk
	task automatic do_op(input fsr_pkg::fsr_op_t op, input logic [25:0] a);
		int n;
		@(negedge clk);
		chk("cmd ready", 16'h0001, {15'h0000, cmd_ready});
		cmd.op = op;
		cmd.addr = a;
		cmd_valid = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
		chk("cmd taken", 16'h0000, {15'h0000, cmd_ready});
		n = 0;
		while (rsp_valid !== 1'b1 && n < 5000) begin
			@(negedge clk);
			n++;
		end
		if (n >= 5000) chk("response", 16'h0001, 16'h0000);
		got = rsp;
	endtask : do_op
	task automatic esr_chk(input logic [15:0] exp, input logic rdy);
		do_op(fsr_pkg::OP_ESR_READ, 26'h0000000);
		chk("status data", exp, got.data);
		chk("status ready", {15'h0000, rdy}, {15'h0000, got.ready});
	endtask : esr_chk
	task automatic release_after(input int n);
		repeat (n) @(negedge clk);
		busy_req = 1'b0;
	endtask : release_after
	task automatic load_res(input logic [15:0] v);
		res_in = v;
		@(negedge clk) res_load = 1'b1;
		@(negedge clk) res_load = 1'b0;
	endtask : load_res
	// ==========================================================
	// Scenarios
	task automatic t_basic();
		esr_chk(16'h0080, 1'b1);
		do_op(fsr_pkg::OP_READ, 26'h0000100);
		chk("array", 16'h1234, got.data);
		busy_req = 1'b1;
		esr_chk(16'h0000, 1'b0);
		do_op(fsr_pkg::OP_READ, 26'h0000100);
		chk("poll bit", 16'h0001, {15'h0000, got.data[7]});
		busy_req = 1'b0;
		$display("test basic done");
	endtask : t_basic
	task automatic t_results();
		load_res(16'h003A);
		esr_chk(16'h00BA, 1'b1);
		busy_req = 1'b1;
		do_op(fsr_pkg::OP_ESR_CLEAR, 26'h0000000);
		busy_req = 1'b0;
		esr_chk(16'h00BA, 1'b1);
		do_op(fsr_pkg::OP_ESR_CLEAR, 26'h0000000);
		esr_chk(16'h0080, 1'b1);
		$display("test results done");
	endtask : t_results
	task automatic t_suspend();
		for (int i = 0; i < 2; i++) begin
			busy_req = 1'b1;
			fork
				release_after(60);
				do_op(i ? fsr_pkg::OP_PROG_SUSPEND : fsr_pkg::OP_ERASE_SUSPEND, 26'h0010000);
			join
			esr_chk(i ? 16'h0084 : 16'h00C0, 1'b1);
			do_op(i ? fsr_pkg::OP_PROG_RESUME : fsr_pkg::OP_ERASE_RESUME, 26'h0010000);
			esr_chk(16'h0080, 1'b1);
		end
		$display("test suspend done");
	endtask : t_suspend
	task automatic t_toggle();
		busy_req = 1'b1;
		fork
			release_after(80);
			do_op(fsr_pkg::OP_TOGGLE_WAIT, 26'h0000200);
		join
		chk("toggle fail", 16'h0000, {15'h0000, got.fail});
		busy_req = 1'b1;
		timeout = 1'b1;
		do_op(fsr_pkg::OP_TOGGLE_WAIT, 26'h0000200);
		chk("timeout fail", 16'h0001, {15'h0000, got.fail});
		busy_req = 1'b0;
		timeout = 1'b0;
		$display("test toggle done");
	endtask : t_toggle
	task automatic t_erase();
		logic [15:0] first;
		busy_req = 1'b1;
		erase_op = 1'b1;
		do_op(fsr_pkg::OP_READ, 26'h0010000);
		first = got.data;
		do_op(fsr_pkg::OP_READ, 26'h0010000);
		chk("erase poll", 16'h0008, got.data & 16'h0088);
		chk("erase toggle", 16'h0004, (first ^ got.data) & 16'h0004);
		do_op(fsr_pkg::OP_READ, 26'h0000200);
		chk("other sector", 16'h0000, got.data & 16'h0004);
		// Protected-only erase gives up well inside its time limit
		fork
			release_after(200);
			do_op(fsr_pkg::OP_TOGGLE_WAIT, 26'h0010000);
		join
		chk("abort fail", 16'h0000, {15'h0000, got.fail});
		chk("data kept", 16'h1234, got.data);
		erase_op = 1'b0;
		do_op(fsr_pkg::OP_ERASE_SUSPEND, 26'h0010000);
		load_res(16'h0100);
		esr_chk(16'h00D0, 1'b1);
		do_op(fsr_pkg::OP_ERASE_RESUME, 26'h0010000);
		busy_req = 1'b1;
		load_res(16'h0008);
		do_op(fsr_pkg::OP_READ, 26'h0000100);
		chk("abort read", 16'h1234, got.data);
		esr_chk(16'h0098, 1'b1);
		busy_req = 1'b0;
		do_op(fsr_pkg::OP_ESR_CLEAR, 26'h0000000);
		esr_chk(16'h0080, 1'b1);
		$display("test erase done");
	endtask : t_erase
	task automatic t_ident();
		do_op(fsr_pkg::OP_ID_ENTER, 26'h0000000);
		repeat (2) begin
			do_op(fsr_pkg::OP_READ, 26'h0000000);
			chk("ident", 16'h005A, got.data);
		end
		do_op(fsr_pkg::OP_ID_EXIT, 26'h0000000);
		do_op(fsr_pkg::OP_READ, 26'h0000000);
		chk("after exit", 16'h1234, got.data);
		$display("test ident done");
	endtask : t_ident
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		print_verdict();
	end
	initial begin
		{clk, cmd_valid, busy_req, timeout, res_load, erase_op} = 6'h00;
		rst = 1'b1;
		res_in = 16'h0000;
		cmd = '0;
		miscompares = 0;
		n_tests = 0;
		repeat (12) @(posedge clk);
		@(negedge clk) rst = 1'b0;
		t_basic();
		t_results();
		t_suspend();
		t_toggle();
		t_erase();
		t_ident();
		print_verdict();
	end
endmodule : test_fsr_host
`default_nettype wire
